//--- common/csp_defines.svh
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

// ==========================================================
// Register offsets
`define CSP_ADDR_CONTROL 3'h0
`define CSP_ADDR_STATUS 3'h1
`define CSP_ADDR_TX_BUFFER 3'h2
`define CSP_ADDR_RX_BUFFER 3'h3

// ==========================================================
// Control register fields
`define CSP_CTL_START 0
`define CSP_CTL_STOP 1
`define CSP_CTL_MODE_LO 2
`define CSP_CTL_MODE_HI 3
`define CSP_CTL_ORDER 4
`define CSP_CTL_EXT 5
`define CSP_CTL_RATE_LO 6
`define CSP_CTL_RATE_HI 7

// ==========================================================
// Status register fields
`define CSP_ST_TX_EMPTY 0
`define CSP_ST_RX_FULL 1
`define CSP_ST_ACTIVE 2
`define CSP_ST_SHIFT 3
`define CSP_ST_TX_ERROR 4
`define CSP_ST_RX_ERROR 5

// ==========================================================
// Values and counts
`define CSP_BYTE_ZERO 8'h00
`define CSP_BIT_LAST 3'h7
`define CSP_BIT_FIRST 3'h0
`define CSP_BIT_STEP 3'h1
`define CSP_TX_EMPTY_RESET 1'b1
`define CSP_IDLE_LEVEL 1'b1
`define CSP_HALF_BASE 8'h04
`define CSP_DIV_ZERO 8'h00
`define CSP_DIV_STEP 8'h01

`endif

//--- common/csp_pkg.sv
package csp_pkg;

    typedef enum logic [1:0] {
        mode_tx,
        mode_rx,
        mode_trx,
        mode_reserved
    } mode_type;

    typedef enum logic {
        st_idle,
        st_shift
    } byte_state_type;

endpackage

//--- common/sck_ctrl_if.sv
`timescale 1ns/1ps

interface sck_ctrl_if;
    logic ext_mode;
    logic [1:0] rate;
    logic run;
    logic abort;
    logic fall;
    logic rise;

    modport engine (
        output ext_mode,
        output rate,
        output run,
        output abort,
        input fall,
        input rise
    );

    modport gen (
        input ext_mode,
        input rate,
        input run,
        input abort,
        output fall,
        output rise
    );
endinterface

//--- hdl/csp_sck_unit.sv
`timescale 1ns/1ps
`include "csp_defines.svh"

module csp_sck_unit (
    input wire logic core_clk,
    input wire logic nrst,
    sck_ctrl_if.gen ctl,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n
);

    // ======================================================
    // External clock sampling
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    wire ext_fall = sck_s3 && !sck_s2;
    wire ext_rise = !sck_s3 && sck_s2;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sck_s1 <= `CSP_IDLE_LEVEL;
            sck_s2 <= `CSP_IDLE_LEVEL;
            sck_s3 <= `CSP_IDLE_LEVEL;
        end else begin
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
        end
    end

    // ======================================================
    // Internal clock generation, halts high when not run
    logic [7:0] div_cnt;
    logic int_fall;
    logic int_rise;
    wire [7:0] half_len = `CSP_HALF_BASE << ctl.rate;
    wire div_go = !sck_out || ctl.run;
    wire div_end = div_go && (div_cnt == half_len - `CSP_DIV_STEP);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= `CSP_DIV_ZERO;
            sck_out <= `CSP_IDLE_LEVEL;
            int_fall <= 1'b0;
            int_rise <= 1'b0;
        end else if (ctl.abort || ctl.ext_mode) begin
            div_cnt <= `CSP_DIV_ZERO;
            sck_out <= `CSP_IDLE_LEVEL;
            int_fall <= 1'b0;
            int_rise <= 1'b0;
        end else begin
            div_cnt <= div_end ? `CSP_DIV_ZERO : (div_go ? div_cnt + `CSP_DIV_STEP : div_cnt);
            sck_out <= div_end ? !sck_out : sck_out;
            int_fall <= div_end && sck_out;
            int_rise <= div_end && !sck_out;
        end
    end

    assign sck_oe_n = ctl.ext_mode;
    assign ctl.fall = ctl.ext_mode ? ext_fall : int_fall;
    assign ctl.rise = ctl.ext_mode ? ext_rise : int_rise;

endmodule // csp_sck_unit

//--- hdl/clocked_serial_port_txrx.sv
`timescale 1ns/1ps
`include "csp_defines.svh"

// Functional notes
// - Writing the transmit buffer clears the transmit-empty flag.
// - Internal clock, transmit: clock halts high without new byte; write resumes it.
// - A byte written during shifting follows the previous byte with no gap.
// - Shifting with empty buffer sets transmit error; interrupt on next falling edge.
// - Clearing start finishes current byte, clears active flag, output stays high.
// - Force-stop halts at once, clears start and both buffers, and clears status except transmit-empty, which is set.
// - Serial output held high while transmit error is set.
// - Mode code 01 is receive only, 10 is transmit and receive.
// - Receive: active flag rises on falling edge, bits sampled on rising edges.
// - Shift-active flag high from first to eighth falling edge of a byte.
// - A full received byte goes to receive buffer, sets full flag, interrupts.
// - Reading receive buffer clears full; internal clock waits high until then.
// - Byte completing with unread buffer sets receive error and interrupts.
// - While receive error is set, incoming bits are discarded.
// - In error, second buffer read gives shift register; error clear clears full.
// - After start clears, receive stops at the end of the current byte.
// - No further interrupts while receive error stays uncorrected.
// - Transmit-receive: empty set on rising edge after load; interrupt with full.
// - External clock: load on first falling edge after start, receive on rise.
// - Mode code 00 transmits one bit per falling edge.
// - Bit order zero is MSB first, one is LSB first, both directions.
// - Internal clock, modes 00 and 10: start waits until a byte is in the transmit buffer.

module clocked_serial_port_txrx (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic si_in,
    output logic so_out,
    output logic serial_irq
);

    // ======================================================
    // Control register
    logic transfer_start_bit;
    logic force_stop_bit;
    csp_pkg::mode_type transfer_mode_field;
    logic bit_order_select;
    logic ext_clk;
    logic [1:0] clk_rate;

    // ======================================================
    // Status register and buffers
    logic tx_empty_flag;
    logic rx_full_flag;
    logic transfer_active_flag;
    logic shift_active_flag;
    logic tx_error_flag;
    logic rx_error_flag;
    logic [7:0] tx_buffer;
    logic [7:0] rx_buffer;

    // ======================================================
    // Shift engine
    csp_pkg::byte_state_type state;
    logic [7:0] shifter;
    logic [2:0] bit_cnt;
    logic empty_pend;
    logic irq_on_fall;
    logic rd_twice;
    logic si_s1;
    logic si_s2;

    // ======================================================
    // Clock unit
    sck_ctrl_if sck_bus ();
    wire fall = sck_bus.fall;
    wire rise = sck_bus.rise;

    csp_sck_unit u_sck (
        .core_clk(core_clk),
        .nrst(nrst),
        .ctl(sck_bus.gen),
        .sck_in(sck_in),
        .sck_out(sck_out),
        .sck_oe_n(sck_oe_n)
    );

    // ======================================================
    // Register decode
    wire wr_ctl = reg_wr && (reg_addr == `CSP_ADDR_CONTROL);
    wire wr_stat = reg_wr && (reg_addr == `CSP_ADDR_STATUS);
    wire wr_tx = reg_wr && (reg_addr == `CSP_ADDR_TX_BUFFER);
    wire rd_stat = reg_rd && (reg_addr == `CSP_ADDR_STATUS);
    wire rd_ctl = reg_rd && (reg_addr == `CSP_ADDR_CONTROL);
    wire rd_rx = reg_rd && (reg_addr == `CSP_ADDR_RX_BUFFER);
    wire abort = force_stop_bit || (wr_ctl && reg_wdata[`CSP_CTL_STOP]);
    wire clr_rx_error = wr_stat && !reg_wdata[`CSP_ST_RX_ERROR] && rx_error_flag;

    // ======================================================
    // Mode selection
    wire has_tx = (transfer_mode_field == csp_pkg::mode_tx) ||
                  (transfer_mode_field == csp_pkg::mode_trx);
    wire has_rx = (transfer_mode_field == csp_pkg::mode_rx) ||
                  (transfer_mode_field == csp_pkg::mode_trx);
    wire mode_ok = transfer_mode_field != csp_pkg::mode_reserved;
    wire trx_mode = transfer_mode_field == csp_pkg::mode_trx;
    wire data_ready = (!has_tx || !tx_empty_flag) && (!has_rx || !rx_full_flag);
    wire in_byte = state == csp_pkg::st_shift;

    // ======================================================
    // Byte events
    wire begin_byte = fall && !in_byte && transfer_start_bit && mode_ok &&
                      (ext_clk || data_ready);
    wire last_bit = bit_cnt == `CSP_BIT_LAST;
    wire rise_last = rise && in_byte && last_bit;
    wire fall_last = fall && in_byte && last_bit;
    wire tx_load = begin_byte && has_tx && !tx_empty_flag;
    wire tx_miss = begin_byte && has_tx && tx_empty_flag;
    wire rx_overrun = rise_last && has_rx && rx_full_flag && !rx_error_flag;
    wire rx_capture = rise_last && has_rx && !rx_full_flag && !rx_error_flag;
    wire sample_en = rise && in_byte && !rx_error_flag;

    // ======================================================
    // Bit order selection
    wire [7:0] shift_in = bit_order_select ? {si_s2, shifter[7:1]} :
                          {shifter[6:0], si_s2};
    wire load_bit = bit_order_select ? tx_buffer[0] : tx_buffer[7];
    wire cur_bit = bit_order_select ? shifter[0] : shifter[7];

    // ======================================================
    // Next values of the engine
    wire run = in_byte || (transfer_start_bit && mode_ok && data_ready);
    wire [7:0] next_shifter = tx_load ? tx_buffer : (sample_en ? shift_in : shifter);
    wire [2:0] next_bit_cnt = begin_byte ? `CSP_BIT_FIRST :
                              ((rise && in_byte) ? bit_cnt + `CSP_BIT_STEP : bit_cnt);
    wire next_in_byte = begin_byte || (in_byte && !rise_last);
    wire next_shift_active = begin_byte || (shift_active_flag && !fall_last);
    wire next_active = begin_byte ||
                       (transfer_active_flag && (in_byte || transfer_start_bit));
    wire next_empty_pend = tx_load || (empty_pend && !rise);

    // ======================================================
    // Next values of the status flags
    wire empty_set = empty_pend && rise;
    wire next_tx_empty = empty_set || (tx_empty_flag && !wr_tx);
    wire next_tx_error = tx_miss || tx_error_flag;
    wire next_rx_error = rx_overrun || (rx_error_flag && !clr_rx_error);
    wire rx_read_clear = rd_rx && !rx_error_flag;
    wire next_rx_full = rx_capture ||
                        (rx_full_flag && !rx_read_clear && !clr_rx_error);
    wire next_rd_twice = rx_error_flag && !clr_rx_error && (rd_twice || rd_rx);

    // ======================================================
    // Interrupt
    wire fall_irq_set = (empty_set && !trx_mode) || tx_miss;
    wire next_irq_on_fall = fall_irq_set || (irq_on_fall && !fall);
    wire irq_event = (fall && irq_on_fall) || rx_capture || rx_overrun;
    wire next_irq = irq_event && !rx_error_flag;

    // ======================================================
    // Serial output
    wire bit_out = begin_byte ? load_bit : cur_bit;
    wire drive_bit = has_tx && (tx_load || (fall && in_byte));
    wire hold_bit = in_byte;
    wire next_so = next_tx_error ? `CSP_IDLE_LEVEL :
                   (drive_bit ? bit_out :
                   (hold_bit ? so_out : `CSP_IDLE_LEVEL));

    // ======================================================
    // Read data selection
    logic [7:0] status_word;

    always_comb begin
        status_word = `CSP_BYTE_ZERO;
        status_word[`CSP_ST_TX_EMPTY] = tx_empty_flag;
        status_word[`CSP_ST_RX_FULL] = rx_full_flag;
        status_word[`CSP_ST_ACTIVE] = transfer_active_flag;
        status_word[`CSP_ST_SHIFT] = shift_active_flag;
        status_word[`CSP_ST_TX_ERROR] = tx_error_flag;
        status_word[`CSP_ST_RX_ERROR] = rx_error_flag;
    end

    logic [7:0] ctl_word;

    always_comb begin
        ctl_word = `CSP_BYTE_ZERO;
        ctl_word[`CSP_CTL_START] = transfer_start_bit;
        ctl_word[`CSP_CTL_STOP] = force_stop_bit;
        ctl_word[`CSP_CTL_MODE_HI:`CSP_CTL_MODE_LO] = transfer_mode_field;
        ctl_word[`CSP_CTL_ORDER] = bit_order_select;
        ctl_word[`CSP_CTL_EXT] = ext_clk;
        ctl_word[`CSP_CTL_RATE_HI:`CSP_CTL_RATE_LO] = clk_rate;
    end

    wire [7:0] rx_word = (rx_error_flag && rd_twice) ? shifter : rx_buffer;
    wire [7:0] next_rdata = rd_stat ? status_word :
                            (rd_ctl ? ctl_word :
                            (rd_rx ? rx_word : `CSP_BYTE_ZERO));

    // ======================================================
    // Clock unit hookup
    assign sck_bus.ext_mode = ext_clk;
    assign sck_bus.rate = clk_rate;
    assign sck_bus.run = run;
    assign sck_bus.abort = abort;

    // ======================================================
    // Serial input synchroniser
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
        end else begin
            si_s1 <= si_in;
            si_s2 <= si_s1;
        end
    end

    // ======================================================
    // Control register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            transfer_start_bit <= 1'b0;
            force_stop_bit <= 1'b0;
            transfer_mode_field <= csp_pkg::mode_tx;
            bit_order_select <= 1'b0;
            ext_clk <= 1'b0;
            clk_rate <= 2'h0;
        end else if (wr_ctl) begin
            transfer_start_bit <= reg_wdata[`CSP_CTL_START] && !reg_wdata[`CSP_CTL_STOP];
            force_stop_bit <= reg_wdata[`CSP_CTL_STOP];
            transfer_mode_field <= csp_pkg::mode_type'(
                reg_wdata[`CSP_CTL_MODE_HI:`CSP_CTL_MODE_LO]);
            bit_order_select <= reg_wdata[`CSP_CTL_ORDER];
            ext_clk <= reg_wdata[`CSP_CTL_EXT];
            clk_rate <= reg_wdata[`CSP_CTL_RATE_HI:`CSP_CTL_RATE_LO];
        end
    end

    // ======================================================
    // Buffers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_buffer <= `CSP_BYTE_ZERO;
            rx_buffer <= `CSP_BYTE_ZERO;
        end else if (abort) begin
            tx_buffer <= `CSP_BYTE_ZERO;
            rx_buffer <= `CSP_BYTE_ZERO;
        end else begin
            tx_buffer <= wr_tx ? reg_wdata : tx_buffer;
            rx_buffer <= rx_capture ? shift_in : rx_buffer;
        end
    end

    // ======================================================
    // Status flags
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_empty_flag <= `CSP_TX_EMPTY_RESET;
            rx_full_flag <= 1'b0;
            tx_error_flag <= 1'b0;
            rx_error_flag <= 1'b0;
            rd_twice <= 1'b0;
        end else if (abort) begin
            tx_empty_flag <= `CSP_TX_EMPTY_RESET;
            rx_full_flag <= 1'b0;
            tx_error_flag <= 1'b0;
            rx_error_flag <= 1'b0;
            rd_twice <= 1'b0;
        end else begin
            tx_empty_flag <= next_tx_empty;
            rx_full_flag <= next_rx_full;
            tx_error_flag <= next_tx_error;
            rx_error_flag <= next_rx_error;
            rd_twice <= next_rd_twice;
        end
    end

    // ======================================================
    // Byte sequencing
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= csp_pkg::st_idle;
            bit_cnt <= `CSP_BIT_FIRST;
            shifter <= `CSP_BYTE_ZERO;
            empty_pend <= 1'b0;
        end else if (abort) begin
            state <= csp_pkg::st_idle;
            bit_cnt <= `CSP_BIT_FIRST;
            shifter <= `CSP_BYTE_ZERO;
            empty_pend <= 1'b0;
        end else begin
            state <= next_in_byte ? csp_pkg::st_shift : csp_pkg::st_idle;
            bit_cnt <= next_bit_cnt;
            shifter <= next_shifter;
            empty_pend <= next_empty_pend;
        end
    end

    // ======================================================
    // Activity flags
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            transfer_active_flag <= 1'b0;
            shift_active_flag <= 1'b0;
        end else if (abort) begin
            transfer_active_flag <= 1'b0;
            shift_active_flag <= 1'b0;
        end else begin
            transfer_active_flag <= next_active;
            shift_active_flag <= next_shift_active;
        end
    end

    // ======================================================
    // Serial output and interrupt
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            so_out <= `CSP_IDLE_LEVEL;
            irq_on_fall <= 1'b0;
            serial_irq <= 1'b0;
        end else if (abort) begin
            so_out <= `CSP_IDLE_LEVEL;
            irq_on_fall <= 1'b0;
            serial_irq <= 1'b0;
        end else begin
            so_out <= next_so;
            irq_on_fall <= next_irq_on_fall;
            serial_irq <= next_irq;
        end
    end

    // ======================================================
    // Register read port
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `CSP_BYTE_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // clocked_serial_port_txrx

//--- verif/csp_link_model.sv
`timescale 1ns/1ps

module csp_link_model (
    input wire logic sck,
    input wire logic so,
    output logic si,
    output logic sck_drv
);
    // ==========
    // Far-side shift registers, MSB first
    logic [7:0] tx_byte = 8'hff;
    logic [7:0] rx_byte = 8'h00;

    initial begin
        si = 1'b1;
        sck_drv = 1'b1;
    end

    always @(negedge sck) begin
        si <= tx_byte[7];
        tx_byte <= {tx_byte[6:0], tx_byte[7]};
    end

    always @(posedge sck) begin
        rx_byte <= {rx_byte[6:0], so};
    end

    // External master clock, 160 ns period
    task automatic run_clocks(input int n);
        #3;
        repeat (n) begin
            #80 sck_drv = 1'b0;
            #80 sck_drv = 1'b1;
        end
    endtask
endmodule // csp_link_model

//--- verif/clocked_serial_port_txrx_checker.sv
`timescale 1ns/1ps

module csp_port_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sck_in,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic si_in,
    input wire logic so_out,
    input wire logic serial_irq
);
    // ==========
    // Falls since last buffer access
    logic sck_q;
    logic [4:0] falls;
    wire sck_fall = sck_q && !sck_out && !sck_oe_n;
    wire buf_acc = (reg_wr && reg_addr == 3'h2) || (reg_rd && reg_addr == 3'h3);
    wire stop_wr = reg_wr && reg_addr == 3'h0 && reg_wdata[1];
    wire ctl_wr = reg_wr && reg_addr == 3'h0;
    wire ext_bit = reg_wdata[5];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sck_q <= 1'b1;
            falls <= 5'h00;
        end else begin
            sck_q <= sck_out;
            if (buf_acc) begin
                falls <= 5'h00;
            end else if (sck_fall && falls != 5'h1f) begin
                falls <= falls + 5'h01;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // ==========
    // Assertions
    a_so_sck_low: assert property ($changed(so_out) && !sck_oe_n |-> !sck_out || so_out)
        else $error("so_out left idle level while sck high");
    a_sck_low_span: assert property ($fell(sck_out) |-> !sck_out[*4] ##1 sck_out)
        else $error("sck low phase not four cycles");
    a_irq_single: assert property (serial_irq |=> !serial_irq)
        else $error("irq longer than one cycle");
    a_wait_bound: assert property (falls <= 5'h10)
        else $error("sck ran on without buffer access");
    a_stop_quiet: assert property (stop_wr |=> ##1 (so_out && sck_out && !serial_irq)[*3])
        else $error("force stop did not halt");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_oe_ext: assert property (ctl_wr |=> sck_oe_n == $past(ext_bit))
        else $error("sck enable does not follow clock select");
    a_irq_edge: assert property (serial_irq && !sck_oe_n |->
        $past(sck_out, 3) != $past(sck_out, 2) || $past(sck_out, 2) != $past(sck_out)
        || $past(sck_out) != sck_out)
        else $error("irq away from sck edge");

    c_irq: cover property (serial_irq);
    c_fall: cover property (sck_fall);
    c_stop: cover property (stop_wr);
endmodule // csp_port_checker

bind clocked_serial_port_txrx csp_port_checker csp_port_checker_i (.*);

//--- verif/tb_clocked_serial_port_txrx.sv
`timescale 1ns/1ps
`include "csp_defines.svh"

module tb_clocked_serial_port_txrx;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sck_out, sck_oe_n, so_out, serial_irq, si_in, ext_sck;
    wire sck_line = sck_oe_n ? ext_sck : sck_out;
    int n_fail = 0;
    int samples_checked = 0;
    int n_irq = 0;
    int n0;
    logic [7:0] d;
    logic [7:0] sdv [3] = '{8'h81, 8'h7e, 8'h55};
    realtime t1;

    clocked_serial_port_txrx clocked_serial_port_txrx_i (.core_clk(core_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .si_in(si_in), .so_out(so_out), .serial_irq(serial_irq));
    csp_link_model csp_link_model_i (.sck(sck_line), .so(so_out), .si(si_in), .sck_drv(ext_sck));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    always @(negedge core_clk) begin
        if (serial_irq === 1'b1) n_irq++;
    end

    // ==========
    // Bus and check tasks
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    task automatic wait_irq;
        int k;
        k = 0;
        @(negedge core_clk);
        while (serial_irq !== 1'b1 && k < 2000) begin
            @(negedge core_clk);
            k++;
        end
        chk(8'(k < 2000), 8'h01);
        @(posedge core_clk);
    endtask

    task automatic wait_idle;
        int k;
        k = 0;
        d = 8'h04;
        while (d[2] !== 1'b0 && k < 200) begin
            rd(`CSP_ADDR_STATUS);
            k++;
        end
        chk(8'(k < 200), 8'h01);
    endtask

    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction

    // One byte: c = {order, mode}
    task automatic xfer(input logic [2:0] c, input logic [7:0] td, input logic [7:0] sd);
        csp_link_model_i.tx_byte = sd;
        if (c[1:0] != 2'b01) wr(`CSP_ADDR_TX_BUFFER, td);
        wr(`CSP_ADDR_CONTROL, {3'h0, c, 2'h1});
        wait_irq;
        wr(`CSP_ADDR_CONTROL, {3'h0, c, 2'h0});
        if (c[1:0] != 2'b00) begin
            rd(`CSP_ADDR_RX_BUFFER);
            chk(d, c[2] ? rev(sd) : sd);
        end
        wait_idle;
        if (c[1:0] != 2'b01) chk(csp_link_model_i.rx_byte, c[2] ? rev(td) : td);
        chk(8'(so_out), 8'h01);
    endtask

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_fail++;
        finish_test;
    end

    // ==========
    // Test sequence
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`CSP_ADDR_STATUS);
        chk(d, 8'h01);
        rd(3'h5);
        chk(d, 8'h00);
        wr(`CSP_ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge core_clk);
        chk(8'(sck_out), 8'h01);
        wr(`CSP_ADDR_TX_BUFFER, 8'ha1);
        wait_irq;
        t1 = $realtime;
        wr(`CSP_ADDR_TX_BUFFER, 8'hb2);
        rd(`CSP_ADDR_STATUS);
        chk(d & 8'h01, 8'h00);
        wait_irq;
        chk(8'(($realtime - t1) / 8), 8'h40);
        repeat (100) @(posedge core_clk);
        chk(8'(sck_out), 8'h01);
        wr(`CSP_ADDR_TX_BUFFER, 8'hc3);
        n0 = 0;
        while (sck_out === 1'b1 && n0 < 40) begin
            @(negedge core_clk);
            n0++;
        end
        chk(8'(n0 <= 10), 8'h01);
        wr(`CSP_ADDR_CONTROL, 8'h00);
        wait_idle;
        chk(csp_link_model_i.rx_byte, 8'hc3);
        for (int i = 0; i < 6; i++) xfer({i[0], 2'(i / 2)}, 8'h3c ^ 8'(i * 17), 8'hc5 ^ 8'(i));
        wr(`CSP_ADDR_CONTROL, 8'h21);
        n0 = n_irq;
        csp_link_model_i.run_clocks(8);
        repeat (8) @(posedge core_clk);
        rd(`CSP_ADDR_STATUS);
        chk(d & 8'h10, 8'h10);
        chk(8'(n_irq - n0), 8'h01);
        chk(csp_link_model_i.rx_byte, 8'hff);
        wr(`CSP_ADDR_CONTROL, 8'h02);
        rd(`CSP_ADDR_STATUS);
        chk(d, 8'h01);
        rd(`CSP_ADDR_CONTROL);
        chk(d, 8'h02);
        wr(`CSP_ADDR_CONTROL, 8'h24);
        wr(`CSP_ADDR_CONTROL, 8'h25);
        n0 = n_irq;
        for (int j = 0; j < 3; j++) begin
            csp_link_model_i.tx_byte = sdv[j];
            csp_link_model_i.run_clocks(8);
        end
        repeat (8) @(posedge core_clk);
        chk(8'(n_irq - n0), 8'h02);
        rd(`CSP_ADDR_STATUS);
        chk(d & 8'h22, 8'h22);
        wr(`CSP_ADDR_CONTROL, 8'h24);
        rd(`CSP_ADDR_RX_BUFFER);
        chk(d, 8'h81);
        rd(`CSP_ADDR_RX_BUFFER);
        chk(d, 8'h7e);
        wr(`CSP_ADDR_STATUS, 8'h00);
        csp_link_model_i.run_clocks(8);
        repeat (8) @(posedge core_clk);
        rd(`CSP_ADDR_STATUS);
        chk(d, 8'h01);
        wr(`CSP_ADDR_CONTROL, 8'h25);
        csp_link_model_i.tx_byte = 8'h3a;
        csp_link_model_i.run_clocks(8);
        repeat (8) @(posedge core_clk);
        rd(`CSP_ADDR_RX_BUFFER);
        chk(d, 8'h3a);
        finish_test;
    end
endmodule // tb_clocked_serial_port_txrx
